// File: rtl/osc_pkg.sv
// Constants for the oscillator source control block.
// Assumes an 8-bit register port and oscillator tick pins from the analog side.
`default_nettype none
package osc_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OSC_PCC_ADDR      = 8'hC4;
	localparam logic [7:0] OSC_STAT_ADDR     = 8'hC5;
	localparam logic [7:0] OSC_EVT_STAT_ADDR = 8'hCC;
	localparam logic [7:0] OSC_EVT_MASK_ADDR = 8'hCD;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int OSC_PCC_SEL     = 7;
	localparam int OSC_PCC_RCFLAG  = 6;
	localparam int OSC_PCC_RSEL    = 5;
	localparam int OSC_PCC_SUBDIS  = 4;
	localparam int OSC_PCC_MAINDIS = 3;
	localparam int OSC_PCC_LSB     = 0;
	localparam int OSC_ST_SUBRDY   = 7;
	localparam int OSC_ST_HIP      = 6;
	localparam int OSC_ST_LIP      = 5;
	localparam int OSC_ST_MAINRDY  = 4;
	localparam int OSC_EVT_MAIN    = 0;
	localparam int OSC_EVT_SUB     = 1;
	localparam int OSC_EVT_W       = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] OSC_PCC_RESET      = 8'h81;
	localparam logic       OSC_MAIN_RDY_RESET = 1'b1;
	localparam logic       OSC_SUB_RDY_RESET  = 1'b0;
	localparam logic [1:0] OSC_EVT_RESET      = 2'h0;

	// ----------------------------------------------------------------
	// Warm-up counts, in oscillator clocks
	// ----------------------------------------------------------------
	localparam int OSC_CNT_W           = 17;
	localparam int OSC_MAIN_WARM_SHORT = 4096;
	localparam int OSC_MAIN_WARM_LONG  = 65536;
	localparam int OSC_SUB_WARM_SHORT  = 1024;
	localparam int OSC_SUB_WARM_LONG   = 65536;

endpackage
`default_nettype wire

// File: rtl/osc_warm_if.sv
// Link between the control logic and one warm-up counter.
// Assumes both ends run on sys_clk.
`timescale 1ns/10ps
`default_nettype none
interface osc_warm_if;
	logic run;
	logic tick;
	logic longSel;
	logic ready;

	modport ctl (output run, output tick, output longSel, input ready);
	modport cnt (input run, input tick, input longSel, output ready);
endinterface
`default_nettype wire

// File: rtl/osc_sync.sv
// Two-flop synchroniser for pins from outside the sys_clk domain.
// Assumes inputs are asynchronous levels.
`timescale 1ns/10ps
`default_nettype none
module osc_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         reset_n,
	input  wire logic         clkEn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} osc_sync_t;

	osc_sync_t st_q;
	osc_sync_t st_d;

	always_comb begin
		st_d    = st_q;
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
		end else if (clkEn) begin
			st_q <= st_d;
		end
	end

	assign q = st_q.s2;
endmodule // osc_sync
`default_nettype wire

// File: rtl/osc_warmup.sv
// Warm-up counter for one oscillator.
// Assumes tick is a one-cycle pulse per oscillator clock, on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module osc_warmup #(
	parameter int   SHORT_CNT  = 1024,
	parameter int   LONG_CNT   = 65536,
	parameter logic READY_INIT = 1'b0
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	osc_warm_if.cnt  w
);
	import osc_pkg::*;

	localparam logic [OSC_CNT_W-1:0] SHORT_LAST = OSC_CNT_W'(SHORT_CNT - 1);
	localparam logic [OSC_CNT_W-1:0] LONG_LAST  = OSC_CNT_W'(LONG_CNT - 1);

	typedef struct packed {
		logic [OSC_CNT_W-1:0] cnt;
		logic                 ready;
	} osc_warm_t;

	osc_warm_t            st_q;
	osc_warm_t            st_d;
	logic [OSC_CNT_W-1:0] lastCnt;

	assign lastCnt = w.longSel ? LONG_LAST : SHORT_LAST; // RULE_10 RULE_13

	always_comb begin
		st_d = st_q;
		if (!w.run) begin
			st_d.cnt   = '0;
			st_d.ready = 1'b0;
		end else if (w.tick && !st_q.ready) begin
			if (st_q.cnt == lastCnt) begin
				st_d.ready = 1'b1; // RULE_17
			end else begin
				st_d.cnt = st_q.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '{cnt: '0, ready: READY_INIT};
		end else if (clkEn) begin
			st_q <= st_d;
		end
	end

	// Stopped oscillator reports not ready at once
	assign w.ready = st_q.ready & w.run;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_ready_at_count: assert property (clkEn && $rose(st_q.ready) |-> // RULE_17
		$past(w.tick) && $past(st_q.cnt) == $past(lastCnt))
		else $error("ready rose before the warm-up count was reached");
endmodule // osc_warmup
`default_nettype wire

// File: rtl/osc_source_ctl.sv
// Oscillator source control: clock source select, oscillator disables,
// warm-up tracking, power-down resume and interrupt-level status.
// Assumes CPU strobes on sys_clk; oscillator ticks and option straps are pins.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// (RULE_01) Source-select one runs from crystal, zero from RC oscillator.
// (RULE_02) Setting source-select ignored unless main ready and main not disabled.
// (RULE_03) Read-only RC flag is one while running from RC, else zero.
// (RULE_04) Power-down resume: continue on RC if resume-select, else stall for warm-up. The code does not stall while main disable is set.
// (RULE_05) Sub-oscillator disable bit stops the sub-oscillator.
// (RULE_06) Main disable stops crystal; may be set only while running from RC.
// (RULE_07) Clearing main disable restarts crystal; ready set after warm-up.
// (RULE_08) Software always writes one into bit zero of the control register.
// (RULE_09) Sub ready set after warm-up, cleared whenever sub disable is set.
// (RULE_10) Sub warm-up is 1024 or 65536 clocks, chosen by option strap.
// (RULE_11) Main ready cleared whenever the crystal restarts or is disabled.
// (RULE_12) Main ready reads one after power-on reset.
// (RULE_13) Crystal warm-up is 4096 or 65536 clocks, chosen by option strap.
// (RULE_14) High-priority-active set during high service, cleared by its return.
// (RULE_15) Low-priority-active set during low service, cleared by its return.
// (RULE_16) Software waits ten instructions after sub ready before switching to it.
// (RULE_17) Each counter counts its own oscillator and sets ready at the count.
module osc_source_ctl #(
	parameter int MAIN_WARM_LONG = osc_pkg::OSC_MAIN_WARM_LONG,
	parameter int SUB_WARM_LONG  = osc_pkg::OSC_SUB_WARM_LONG
) (
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic       clkEn,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdData,
	input  wire logic       mainOscClk,
	input  wire logic       subOscClk,
	input  wire logic       mainWarmLong,
	input  wire logic       subWarmLong,
	input  wire logic       pdEnter,
	input  wire logic       pdWake,
	input  wire logic       intEnterHigh,
	input  wire logic       intEnterLow,
	input  wire logic       intReturn,
	output logic            sysClkSelXtal,
	output logic            mainOscEnable,
	output logic            subOscEnable,
	output logic            cpuStall,
	output logic            irq
);
	import osc_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                 sel;
		logic                 rsel;
		logic                 subDis;
		logic                 mainDis;
		logic                 lsb;
		logic                 high_prio_active;
		logic                 low_prio_active;
		logic                 pd;
		logic                 stall;
		logic                 mainEn;
		logic                 subEn;
		logic                 mainTickPrev;
		logic                 subTickPrev;
		logic                 mainRdyPrev;
		logic                 subRdyPrev;
		logic [OSC_EVT_W-1:0] evt;
		logic [OSC_EVT_W-1:0] mask;
		logic [7:0]           rdData;
		logic                 irq;
	} osc_state_t;

	localparam osc_state_t ST_RESET = '{
		sel:          OSC_PCC_RESET[OSC_PCC_SEL],
		rsel:         OSC_PCC_RESET[OSC_PCC_RSEL],
		subDis:       OSC_PCC_RESET[OSC_PCC_SUBDIS],
		mainDis:      OSC_PCC_RESET[OSC_PCC_MAINDIS],
		lsb:          OSC_PCC_RESET[OSC_PCC_LSB],
		high_prio_active:          1'b0,
		low_prio_active:          1'b0,
		pd:           1'b0,
		stall:        1'b0,
		mainEn:       ~OSC_PCC_RESET[OSC_PCC_MAINDIS],
		subEn:        ~OSC_PCC_RESET[OSC_PCC_SUBDIS],
		mainTickPrev: 1'b0,
		subTickPrev:  1'b0,
		mainRdyPrev:  OSC_MAIN_RDY_RESET,
		subRdyPrev:   OSC_SUB_RDY_RESET,
		evt:          OSC_EVT_RESET,
		mask:         OSC_EVT_RESET,
		rdData:       8'h00,
		irq:          1'b0
	};

	osc_state_t st_q;
	osc_state_t st_d;

	// ----------------------------------------------------------------
	// Pin synchronisers and warm-up counters
	// ----------------------------------------------------------------
	logic [3:0] pinSync;
	logic       mainTick;
	logic       subTick;
	logic       mainRdy;
	logic       subRdy;

	osc_sync #(.W(4)) u_sync (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.clkEn   (clkEn),
		.d       ({subWarmLong, mainWarmLong, subOscClk, mainOscClk}),
		.q       (pinSync)
	);

	assign mainTick = pinSync[0] & ~st_q.mainTickPrev;
	assign subTick  = pinSync[1] & ~st_q.subTickPrev;

	osc_warm_if mainW ();
	osc_warm_if subW ();

	assign mainW.run     = st_q.mainEn; // RULE_07 RULE_11
	assign mainW.tick    = mainTick; // RULE_17
	assign mainW.longSel = pinSync[2]; // RULE_13
	assign subW.run      = st_q.subEn; // RULE_09
	assign subW.tick     = subTick; // RULE_17
	assign subW.longSel  = pinSync[3]; // RULE_10
	assign mainRdy       = mainW.ready;
	assign subRdy        = subW.ready;

	osc_warmup #(
		.SHORT_CNT  (OSC_MAIN_WARM_SHORT),
		.LONG_CNT   (MAIN_WARM_LONG),
		.READY_INIT (OSC_MAIN_RDY_RESET) // RULE_12
	) u_main_warm (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.clkEn   (clkEn),
		.w       (mainW)
	);

	osc_warmup #(
		.SHORT_CNT  (OSC_SUB_WARM_SHORT),
		.LONG_CNT   (SUB_WARM_LONG),
		.READY_INIT (OSC_SUB_RDY_RESET)
	) u_sub_warm (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.clkEn   (clkEn),
		.w       (subW)
	);

	// ----------------------------------------------------------------
	// Register decode and read views
	// ----------------------------------------------------------------
	logic                 wrPcc;
	logic                 wrEvt;
	logic                 wrMask;
	logic [7:0]           pccView;
	logic [7:0]           statView;
	logic [OSC_EVT_W-1:0] evtSet;

	assign wrPcc  = regWr && regAddr == OSC_PCC_ADDR;
	assign wrEvt  = regWr && regAddr == OSC_EVT_STAT_ADDR;
	assign wrMask = regWr && regAddr == OSC_EVT_MASK_ADDR;

	always_comb begin
		pccView                  = 8'h00;
		pccView[OSC_PCC_SEL]     = st_q.sel;
		pccView[OSC_PCC_RCFLAG]  = ~st_q.sel; // RULE_03
		pccView[OSC_PCC_RSEL]    = st_q.rsel;
		pccView[OSC_PCC_SUBDIS]  = st_q.subDis;
		pccView[OSC_PCC_MAINDIS] = st_q.mainDis;
		pccView[OSC_PCC_LSB]     = st_q.lsb;
		statView                 = 8'h00;
		statView[OSC_ST_SUBRDY]  = subRdy;
		statView[OSC_ST_HIP]     = st_q.high_prio_active;
		statView[OSC_ST_LIP]     = st_q.low_prio_active;
		statView[OSC_ST_MAINRDY] = mainRdy;
	end

	assign evtSet[OSC_EVT_MAIN] = mainRdy & ~st_q.mainRdyPrev;
	assign evtSet[OSC_EVT_SUB]  = subRdy & ~st_q.subRdyPrev;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d              = st_q;
		st_d.mainTickPrev = pinSync[0];
		st_d.subTickPrev  = pinSync[1];
		st_d.mainRdyPrev  = mainRdy;
		st_d.subRdyPrev   = subRdy;

		if (wrPcc) begin
			// Disable first, so one write cannot both select and disable the crystal
			if (!regWrData[OSC_PCC_MAINDIS]) begin
				st_d.mainDis = 1'b0; // RULE_07
			end else if (!st_q.sel) begin
				st_d.mainDis = 1'b1; // RULE_06
			end
			if (!regWrData[OSC_PCC_SEL]) begin
				st_d.sel = 1'b0; // RULE_01
			end else if (mainRdy && !st_q.mainDis && !st_d.mainDis) begin
				st_d.sel = 1'b1; // RULE_02
			end
			st_d.rsel   = regWrData[OSC_PCC_RSEL];
			st_d.subDis = regWrData[OSC_PCC_SUBDIS]; // RULE_05
			st_d.lsb    = regWrData[OSC_PCC_LSB]; // RULE_08
		end

		// Power-down entry and resume
		if (pdEnter) begin
			st_d.pd = 1'b1;
		end else if (pdWake && st_q.pd) begin
			st_d.pd = 1'b0;
			if (st_q.rsel) begin
				st_d.sel = 1'b0; // RULE_04
			end else if (!st_q.mainDis) begin
				st_d.stall = 1'b1; // RULE_04
			end
		end
		if (st_q.stall && mainRdy) begin
			st_d.stall = 1'b0; // RULE_04
		end
		st_d.mainEn = ~st_d.mainDis & ~st_d.pd; // RULE_06 RULE_11
		st_d.subEn  = ~st_d.subDis; // RULE_05

		// Interrupt service levels, return closes the innermost first
		if (intReturn) begin
			if (st_q.high_prio_active) begin
				st_d.high_prio_active = 1'b0; // RULE_14
			end else begin
				st_d.low_prio_active = 1'b0; // RULE_15
			end
		end
		if (intEnterHigh) begin
			st_d.high_prio_active = 1'b1; // RULE_14
		end
		if (intEnterLow) begin
			st_d.low_prio_active = 1'b1; // RULE_15
		end

		// Sticky events, set wins over write-one-to-clear
		if (wrEvt) begin
			st_d.evt = st_q.evt & ~regWrData[OSC_EVT_W-1:0];
		end
		st_d.evt = st_d.evt | evtSet;
		if (wrMask) begin
			st_d.mask = regWrData[OSC_EVT_W-1:0];
		end
		st_d.irq = |(st_d.evt & st_d.mask);

		// Read data valid in the cycle after the strobe only
		st_d.rdData = 8'h00;
		if (regRd) begin
			case (regAddr)
				OSC_PCC_ADDR:      st_d.rdData = pccView;
				OSC_STAT_ADDR:     st_d.rdData = statView;
				OSC_EVT_STAT_ADDR: st_d.rdData = {6'h00, st_q.evt};
				OSC_EVT_MASK_ADDR: st_d.rdData = {6'h00, st_q.mask};
				default:           st_d.rdData = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= ST_RESET;
		end else if (clkEn) begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign regRdData     = st_q.rdData;
	assign sysClkSelXtal = st_q.sel; // RULE_01
	assign mainOscEnable = st_q.mainEn;
	assign subOscEnable  = st_q.subEn;
	assign cpuStall      = st_q.stall;
	assign irq           = st_q.irq;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	sequence s_sub_off;
		!subOscEnable ##1 !subRdy;
	endsequence

	sequence s_wake_stall;
		cpuStall && sysClkSelXtal == $past(sysClkSelXtal);
	endsequence

	a_sel_guard: assert property (clkEn && wrPcc && regWrData[OSC_PCC_SEL] && !st_q.sel // RULE_02
		&& !(mainRdy && !st_q.mainDis) |=> !sysClkSelXtal)
		else $error("source select set without crystal ready");

	a_sel_clear: assert property (clkEn && wrPcc && !regWrData[OSC_PCC_SEL] // RULE_01
		|=> !sysClkSelXtal)
		else $error("source select did not clear");

	a_rc_flag: assert property (clkEn && regRd && regAddr == OSC_PCC_ADDR // RULE_03
		|=> regRdData[OSC_PCC_RCFLAG] == !$past(sysClkSelXtal))
		else $error("RC flag disagrees with source select");

	a_resume_stall: assert property (clkEn && pdWake && !pdEnter && st_q.pd // RULE_04
		&& !st_q.rsel && !st_q.mainDis |=> s_wake_stall)
		else $error("resume on crystal did not stall");

	a_resume_rc: assert property (clkEn && pdWake && !pdEnter && st_q.pd && st_q.rsel // RULE_04
		|=> !sysClkSelXtal && !cpuStall)
		else $error("resume on RC did not continue on RC");

	a_sub_stop: assert property (clkEn && wrPcc && regWrData[OSC_PCC_SUBDIS] // RULE_05
		##1 clkEn |-> s_sub_off)
		else $error("sub oscillator not stopped");

	a_main_dis_rc: assert property (st_q.mainDis |-> !sysClkSelXtal) // RULE_06
		else $error("crystal disabled while selected");

	a_main_restart: assert property (clkEn && wrPcc && !regWrData[OSC_PCC_MAINDIS] // RULE_07
		&& st_q.mainDis && !st_q.pd && !pdEnter |=> mainOscEnable && !mainRdy)
		else $error("crystal restart did not begin from not ready");

	a_main_rdy_off: assert property (!mainOscEnable || $rose(mainOscEnable) |-> !mainRdy) // RULE_11
		else $error("main ready while crystal stopped");

	a_por_ready: assert property ($rose(reset_n) |-> mainRdy) // RULE_12
		else $error("main ready low after reset");

	a_hip_return: assert property (clkEn && intReturn && st_q.high_prio_active && !intEnterHigh // RULE_14
		|=> !st_q.high_prio_active && st_q.low_prio_active == $past(st_q.low_prio_active || intEnterLow))
		else $error("return did not close high level");

	a_lip_return: assert property (clkEn && intReturn && !st_q.high_prio_active && !intEnterLow // RULE_15
		&& !intEnterHigh |=> !st_q.low_prio_active && !st_q.high_prio_active)
		else $error("return did not close low level");

	a_stall_release: assert property (clkEn && cpuStall && mainRdy |=> !cpuStall) // RULE_04
		else $error("stall held after crystal ready");

	a_rd_idle: assert property (clkEn && !regRd |=> regRdData == 8'h00)
		else $error("read data stood beyond its cycle");
endmodule // osc_source_ctl
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the oscillator source control block.
// Assumes the design's own assertions sit in its files; long warm-ups shortened to 16.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import osc_pkg::*;

	// ----------------------------------------------------------------
	// Signals and design instance
	// ----------------------------------------------------------------
	localparam int WARM = 16;
	typedef struct packed {
		logic       isWr;
		logic [7:0] addr;
		logic [7:0] data;
		logic [7:0] mask;
		logic [7:0] expd;
		logic [2:0] outs;
	} osc_row_t;

	logic       sys_clk      = 1'b0;
	logic       reset_n      = 1'b0;
	logic       clkEn        = 1'b1;
	logic [7:0] regAddr      = 8'h00;
	logic [7:0] regWrData    = 8'h00;
	logic       regWr        = 1'b0;
	logic       regRd        = 1'b0;
	logic       mainOscClk   = 1'b0;
	logic       subOscClk    = 1'b0;
	logic       mainWarmLong = 1'b1;
	logic       subWarmLong  = 1'b1;
	logic       pdEnter      = 1'b0;
	logic       pdWake       = 1'b0;
	logic       intEnterHigh = 1'b0;
	logic       intEnterLow  = 1'b0;
	logic       intReturn    = 1'b0;
	logic [7:0] regRdData;
	logic       sysClkSelXtal;
	logic       mainOscEnable;
	logic       subOscEnable;
	logic       cpuStall;
	logic       irq;
	logic [3:0] oscDiv       = 4'h0;
	int         cyc          = 0;
	int         n_fail       = 0;
	int         tests_run    = 0;
	osc_row_t   rows [0:17];

	osc_source_ctl #(.MAIN_WARM_LONG(WARM), .SUB_WARM_LONG(WARM)) osc_source_ctl_i (
		.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .mainOscClk(mainOscClk), .subOscClk(subOscClk),
		.mainWarmLong(mainWarmLong), .subWarmLong(subWarmLong),
		.pdEnter(pdEnter), .pdWake(pdWake), .intEnterHigh(intEnterHigh),
		.intEnterLow(intEnterLow), .intReturn(intReturn),
		.sysClkSelXtal(sysClkSelXtal), .mainOscEnable(mainOscEnable),
		.subOscEnable(subOscEnable), .cpuStall(cpuStall), .irq(irq)
	);

	// ----------------------------------------------------------------
	// Clocks: oscillator pins run free at one eighth of sys_clk
	// ----------------------------------------------------------------
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		oscDiv <= oscDiv + 4'h1;
		mainOscClk <= oscDiv[2];
		subOscClk <= ~oscDiv[2];
		cyc <= cyc + 1;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			$display("CHECK FAILED %0t %s got %h want %h", $time, msg, got, exp);
			n_fail++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d & m, e, "register readback");
	endtask

	// Pulse of {pdEnter, pdWake, intEnterHigh, intEnterLow, intReturn}
	task automatic pls(input logic [4:0] v);
		@(posedge sys_clk);
		{pdEnter, pdWake, intEnterHigh, intEnterLow, intReturn} <= v;
		@(posedge sys_clk);
		{pdEnter, pdWake, intEnterHigh, intEnterLow, intReturn} <= 5'h00;
		#1;
	endtask

	task automatic wait_st(input logic [7:0] m, input int lim);
		logic [7:0] d;
		int         t;
		d = 8'h00;
		t = 0;
		while (t < lim && (d & m) !== m) begin
			rd(OSC_STAT_ADDR, d);
			t += 2;
		end
		chk(d & m, m, "warm-up ready within bound");
	endtask

	task automatic give_verdict();
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#(4 * 70000);
		n_fail++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int tMain;
		int tSub;
		int t0;
		logic [7:0] d;
		rows = '{
			'{1'b0, 8'hC4, 8'h00, 8'hFF, 8'h81, 3'h7},
			'{1'b0, 8'hC5, 8'h00, 8'h70, 8'h10, 3'h7},
			'{1'b1, 8'hC4, 8'h01, 8'h00, 8'h00, 3'h0},
			'{1'b0, 8'hC4, 8'h00, 8'hFF, 8'h41, 3'h3},
			'{1'b1, 8'hC4, 8'h09, 8'h00, 8'h00, 3'h0},
			'{1'b0, 8'hC4, 8'h00, 8'hFF, 8'h49, 3'h1},
			'{1'b0, 8'hC5, 8'h00, 8'h10, 8'h00, 3'h1},
			'{1'b1, 8'hC4, 8'h89, 8'h00, 8'h00, 3'h0},
			'{1'b0, 8'hC4, 8'h00, 8'hFF, 8'h49, 3'h1},
			'{1'b1, 8'hC4, 8'h01, 8'h00, 8'h00, 3'h0},
			'{1'b0, 8'hC5, 8'h00, 8'h10, 8'h00, 3'h3},
			'{1'b1, 8'hC4, 8'h81, 8'h00, 8'h00, 3'h0},
			'{1'b0, 8'hC4, 8'h00, 8'hFF, 8'h41, 3'h3},
			'{1'b1, 8'hC3, 8'hFF, 8'h00, 8'h00, 3'h0},
			'{1'b0, 8'hC3, 8'h00, 8'hFF, 8'h00, 3'h3},
			'{1'b1, 8'hC4, 8'h11, 8'h00, 8'h00, 3'h0},
			'{1'b0, 8'hC5, 8'h00, 8'h80, 8'h00, 3'h2},
			'{1'b0, 8'hC4, 8'h00, 8'hFF, 8'h51, 3'h2}
		};
		repeat (7) @(posedge sys_clk);
		#1 chk({regRdData}, 8'h00, "read data idle in reset");
		chk({3'h0, sysClkSelXtal, mainOscEnable, subOscEnable, cpuStall, irq}, 8'h1C, "reset outs");
		@(posedge sys_clk);
		reset_n <= 1'b1;

		// Ordinary register cases
		foreach (rows[i]) begin
			if (rows[i].isWr) begin
				wr(rows[i].addr, rows[i].data);
			end else begin
				rdchk(rows[i].addr, rows[i].mask, rows[i].expd);
				chk({5'h00, sysClkSelXtal, mainOscEnable, subOscEnable}, {5'h00, rows[i].outs},
					"source and enable outputs");
			end
		end

		// Main restart completes, event and interrupt
		wait_st(8'h10, 600);
		rdchk(OSC_EVT_STAT_ADDR, 8'h01, 8'h01);
		chk({7'h00, irq}, 8'h00, "masked event");
		wr(OSC_EVT_MASK_ADDR, 8'h01);
		#1 chk({7'h00, irq}, 8'h01, "unmasked event");
		wr(OSC_EVT_STAT_ADDR, 8'h01);
		#1 chk({7'h00, irq}, 8'h00, "event cleared");

		// Sub restart and ready
		wr(OSC_PCC_ADDR, 8'h01);
		wait_st(8'h80, 600);
		rdchk(OSC_EVT_STAT_ADDR, 8'h02, 8'h02);
		repeat (10) @(posedge sys_clk);

		// Back to crystal, then disable refused while on crystal
		wr(OSC_PCC_ADDR, 8'h81);
		#1 chk({7'h00, sysClkSelXtal}, 8'h01, "crystal selected");
		wr(OSC_PCC_ADDR, 8'h89);
		rdchk(OSC_PCC_ADDR, 8'hFF, 8'h81);
		chk({7'h00, mainOscEnable}, 8'h01, "crystal kept running");

		// Interrupt service levels
		pls(5'h04);
		rdchk(OSC_STAT_ADDR, 8'h60, 8'h40);
		pls(5'h02);
		rdchk(OSC_STAT_ADDR, 8'h60, 8'h60);
		pls(5'h01);
		rdchk(OSC_STAT_ADDR, 8'h60, 8'h20);
		pls(5'h01);
		rdchk(OSC_STAT_ADDR, 8'h60, 8'h00);

		// Power-down resume stalling for crystal warm-up
		pls(5'h10);
		chk({7'h00, mainOscEnable}, 8'h00, "crystal stopped in power-down");
		rdchk(OSC_STAT_ADDR, 8'h10, 8'h00);
		pls(5'h08);
		chk({7'h00, cpuStall}, 8'h01, "stall on resume");
		for (int i = 0; i < 600 && cpuStall === 1'b1; i++) begin
			@(posedge sys_clk);
		end
		#1 chk({6'h00, cpuStall, sysClkSelXtal}, 8'h01, "stall released on crystal");
		rdchk(OSC_STAT_ADDR, 8'h10, 8'h10);

		// Power-down resume on the RC oscillator
		wr(OSC_PCC_ADDR, 8'hA1);
		pls(5'h10);
		pls(5'h08);
		chk({6'h00, cpuStall, sysClkSelXtal}, 8'h00, "resume on RC without stall");
		rdchk(OSC_PCC_ADDR, 8'hC0, 8'h40);
		@(posedge sys_clk);
		#1 chk(regRdData, 8'h00, "read data stands one cycle only");

		// Clock enable low freezes all state
		@(posedge sys_clk);
		clkEn <= 1'b0;
		pls(5'h04);
		@(posedge sys_clk);
		clkEn <= 1'b1;
		rdchk(OSC_STAT_ADDR, 8'h40, 8'h00);

		// Short warm-up straps, measured from restart
		@(posedge sys_clk);
		mainWarmLong <= 1'b0;
		subWarmLong <= 1'b0;
		wr(OSC_PCC_ADDR, 8'h39);
		repeat (6) @(posedge sys_clk);
		wr(OSC_PCC_ADDR, 8'h21);
		t0 = cyc;
		tMain = -1;
		tSub = -1;
		while (cyc - t0 < 34000 && tMain < 0) begin
			rd(OSC_STAT_ADDR, d);
			if (d[OSC_ST_SUBRDY] === 1'b1 && tSub < 0)
				tSub = cyc - t0;
			if (d[OSC_ST_MAINRDY] === 1'b1)
				tMain = cyc - t0;
		end
		chk({7'h00, tSub >= OSC_SUB_WARM_SHORT * 8 - 40 && tSub <= OSC_SUB_WARM_SHORT * 8 + 40},
			8'h01, "sub short warm-up length");
		chk({7'h00, tMain >= OSC_MAIN_WARM_SHORT * 8 - 40 && tMain <= OSC_MAIN_WARM_SHORT * 8 + 40},
			8'h01, "crystal short warm-up length");
		give_verdict();
	end
endmodule // tb
`default_nettype wire
